/* verilog/fws_defines.svh */
`ifndef FWS_DEFINES_SVH
`define FWS_DEFINES_SVH

// ==========================================
// Register byte offsets
`define FWS_CTRL0_LOW_OFS 8'h00
`define FWS_CTRL0_HIGH_OFS 8'h04
`define FWS_PLAIN_FIRST_OFS 8'h08
`define FWS_PLAIN_LAST_OFS 8'h24
`define FWS_ERROR_OFS 8'h28
`define FWS_TEMP_UNPROT_OFS 8'h2c
`define FWS_IRQ_STAT_OFS 8'h30
`define FWS_IRQ_MASK_OFS 8'h34
`define FWS_PROT_STAT_OFS 8'h38

// ==========================================
// Plain register indices (offset 0x08 + 4 * index)
`define FWS_PL_FIRST_WIDX 4'h2
`define FWS_PL_SECT_LO 3'h0
`define FWS_PL_SECT_HI 3'h1
`define FWS_PL_ADDR_LO 3'h2
`define FWS_PL_ADDR_HI 3'h3
`define FWS_PL_DATA0_LO 3'h4
`define FWS_PL_DATA0_HI 3'h5
`define FWS_PL_DATA1_LO 3'h6
`define FWS_PL_DATA1_HI 3'h7

// ==========================================
// Field positions
`define FWS_START_BIT 15
`define FWS_SUSPEND_REQ_BIT 14
`define FWS_WPG_BIT 13
`define FWS_DWORD_PROG_SEL_BIT 12
`define FWS_SER_BIT 11
`define FWS_SPR_BIT 8
`define FWS_BUSY_BIT 0
`define FWS_SUSPENDED_BIT 1
`define FWS_RESUME_ERR_BIT 0
`define FWS_PROT_LIMIT_BIT 1
`define FWS_IRQ_DONE_BIT 0
`define FWS_IRQ_ERR_BIT 1
`define FWS_PAIR_WORD_BIT 2

// ==========================================
// Values
`define FWS_REG_RST 16'h0000
`define FWS_PROT_PAIR_ADDR 32'h0008dfbc
`define FWS_PEN_ALL_USED 16'h0000
`define FWS_RESP_OKAY 2'h0
`define FWS_RESP_SLVERR 2'h2
`define FWS_RESP_DECERR 2'h3

`endif

/* verilog/fws_pkg.sv */
package fws_pkg;

  typedef enum logic [2:0] {
    FWS_OP_NONE, FWS_OP_WORD, FWS_OP_DWORD, FWS_OP_ERASE, FWS_OP_PROT
  } fws_op_t;

  typedef enum logic [1:0] {
    FWS_ST_IDLE, FWS_ST_RUN, FWS_ST_SUSPEND_REQ, FWS_ST_NEST
  } fws_state_t;

endpackage : fws_pkg

/* verilog/fws_op_if.sv */
`timescale 1ns/10ps
interface fws_op_if;
  logic start;
  fws_pkg::fws_op_t op;
  logic suspend_req_req;
  logic fl_done;
  logic busy;
  logic suspended;
  logic done;
  logic abort;
  logic erase_done;
  logic fl_go;
  logic fl_suspend_req;
  logic fl_resume;
  logic fl_abort;
  fws_pkg::fws_op_t fl_cmd;

  modport ctl (output start, op, suspend_req_req, fl_done,
    input busy, suspended, done, abort, erase_done, fl_go, fl_suspend_req, fl_resume, fl_abort, fl_cmd);
  modport eng (input start, op, suspend_req_req, fl_done,
    output busy, suspended, done, abort, erase_done, fl_go, fl_suspend_req, fl_resume, fl_abort, fl_cmd);
endinterface : fws_op_if

/* verilog/fws_engine.sv */
`timescale 1ns/10ps
module fws_engine (
  input wire logic ref_clk,
  input wire logic resetn,
  fws_op_if.eng op_if
);

  fws_pkg::fws_state_t state_r, state_nxt;
  fws_pkg::fws_op_t saved_r, saved_nxt, cmd_r, cmd_nxt;
  logic go_nxt, sus_nxt, res_nxt, abt_nxt, dn_nxt, edn_nxt;
  logic go_r, sus_r, res_r, abt_r, dn_r, edn_r;

  // ==========================================
  // Operation sequencing
  wire prog_op_w = (op_if.op == fws_pkg::FWS_OP_WORD) || (op_if.op == fws_pkg::FWS_OP_DWORD);

  always_comb begin
    state_nxt = state_r;
    saved_nxt = saved_r;
    cmd_nxt = cmd_r;
    go_nxt = 1'b0;
    sus_nxt = 1'b0;
    res_nxt = 1'b0;
    abt_nxt = 1'b0;
    dn_nxt = 1'b0;
    edn_nxt = 1'b0;
    case (state_r)
      fws_pkg::FWS_ST_IDLE: begin
        if (op_if.start && op_if.op != fws_pkg::FWS_OP_NONE) begin
          go_nxt = 1'b1;
          cmd_nxt = op_if.op;
          saved_nxt = op_if.op;
          state_nxt = fws_pkg::FWS_ST_RUN;
        end
      end
      fws_pkg::FWS_ST_RUN: begin
        if (op_if.fl_done) begin
          dn_nxt = 1'b1;
          edn_nxt = (saved_r == fws_pkg::FWS_OP_ERASE);
          saved_nxt = fws_pkg::FWS_OP_NONE;
          state_nxt = fws_pkg::FWS_ST_IDLE;
        end else if (op_if.suspend_req_req) begin
          sus_nxt = 1'b1;
          state_nxt = fws_pkg::FWS_ST_SUSPEND_REQ;
        end
      end
      fws_pkg::FWS_ST_SUSPEND_REQ: begin
        if (op_if.fl_done) begin
          dn_nxt = 1'b1;
          edn_nxt = (saved_r == fws_pkg::FWS_OP_ERASE);
          saved_nxt = fws_pkg::FWS_OP_NONE;
          state_nxt = fws_pkg::FWS_ST_IDLE;
        end else if (op_if.start) begin
          if (saved_r == fws_pkg::FWS_OP_ERASE && prog_op_w) begin
            go_nxt = 1'b1;
            cmd_nxt = op_if.op;
            state_nxt = fws_pkg::FWS_ST_NEST;
          end else if (op_if.op == saved_r) begin
            res_nxt = 1'b1;
            state_nxt = fws_pkg::FWS_ST_RUN;
          end else begin
            abt_nxt = 1'b1;
            saved_nxt = fws_pkg::FWS_OP_NONE;
            state_nxt = fws_pkg::FWS_ST_IDLE;
          end
        end
      end
      fws_pkg::FWS_ST_NEST: begin
        // Suspend requests ignored here
        if (op_if.fl_done) begin
          dn_nxt = 1'b1;
          state_nxt = fws_pkg::FWS_ST_SUSPEND_REQ;
        end
      end
      default: begin
        state_nxt = fws_pkg::FWS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= fws_pkg::FWS_ST_IDLE;
      saved_r <= fws_pkg::FWS_OP_NONE;
      cmd_r <= fws_pkg::FWS_OP_NONE;
      {go_r, sus_r, res_r, abt_r, dn_r, edn_r} <= 6'h00;
    end else begin
      state_r <= state_nxt;
      saved_r <= saved_nxt;
      cmd_r <= cmd_nxt;
      {go_r, sus_r, res_r, abt_r, dn_r, edn_r} <=
        {go_nxt, sus_nxt, res_nxt, abt_nxt, dn_nxt, edn_nxt};
    end
  end

  assign op_if.busy = (state_r == fws_pkg::FWS_ST_RUN) || (state_r == fws_pkg::FWS_ST_NEST);
  assign op_if.suspended = (state_r == fws_pkg::FWS_ST_SUSPEND_REQ) || (state_r == fws_pkg::FWS_ST_NEST);
  assign op_if.fl_go = go_r;
  assign op_if.fl_suspend_req = sus_r;
  assign op_if.fl_resume = res_r;
  assign op_if.fl_abort = abt_r;
  assign op_if.fl_cmd = cmd_r;
  assign op_if.done = dn_r;
  assign op_if.abort = abt_r;
  assign op_if.erase_done = edn_r;

  // ==========================================
  // Checks
  AST_SUSPEND_RUN: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r == fws_pkg::FWS_ST_RUN && op_if.suspend_req_req && !op_if.fl_done
    |=> op_if.fl_suspend_req ##1 op_if.suspended && !op_if.busy)
    else $error("suspend request did not suspend the operation");

  AST_NEST_NO_SUSPEND: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r == fws_pkg::FWS_ST_NEST && op_if.suspend_req_req |=> !op_if.fl_suspend_req)
    else $error("program in erase suspend was suspended");

endmodule : fws_engine

/* verilog/fws_top.sv */
`timescale 1ns/10ps
`include "fws_defines.svh"
module fws_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  input wire logic fetch_from_flash,
  input wire logic access_prot_bit,
  input wire logic [15:0] nv_prot_enable_reg,
  output logic fl_go,
  output fws_pkg::fws_op_t fl_cmd,
  output logic [31:0] fl_addr,
  output logic [63:0] fl_wdata,
  output logic [31:0] fl_sectors,
  output logic fl_suspend_req,
  output logic fl_resume,
  output logic fl_abort,
  input wire logic fl_done
);

  fws_op_if op_if ();

  fws_engine u_engine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .op_if(op_if)
  );

  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [15:0] wd_r;
  logic [1:0] wstrb_r, bresp_r, rresp_r;
  logic [15:0] rdata_r, rd_val;
  logic [3:0] sel_r;
  logic suspend_req_r, start_r, temp_r;
  logic [1:0] err_r, irq_stat_r, irq_mask_r;
  logic [15:0] pl_r [8];
  logic [31:0] fl_addr_r, fl_sectors_r;
  logic [63:0] fl_wdata_r;

  // ==========================================
  // Write decode
  wire do_wr = aw_full_r && w_full_r && !bvalid_r;
  wire [7:0] wa = {awaddr_r[7:2], 2'b00};
  wire wr_full16 = &wstrb_r;
  wire wr_ctrl_lo = (wa == `FWS_CTRL0_LOW_OFS);
  wire wr_ctrl_hi = (wa == `FWS_CTRL0_HIGH_OFS);
  wire wr_plain = (wa >= `FWS_PLAIN_FIRST_OFS) && (wa <= `FWS_PLAIN_LAST_OFS);
  wire wr_err = (wa == `FWS_ERROR_OFS);
  wire wr_temp = (wa == `FWS_TEMP_UNPROT_OFS);
  wire wr_istat = (wa == `FWS_IRQ_STAT_OFS);
  wire wr_imask = (wa == `FWS_IRQ_MASK_OFS);
  wire wr_pstat = (wa == `FWS_PROT_STAT_OFS);
  wire wr_flash = wr_ctrl_lo || wr_ctrl_hi || wr_plain;
  wire wr_mapped = wr_flash || wr_err || wr_temp || wr_istat || wr_imask || wr_pstat;
  wire prot_active = !access_prot_bit && !temp_r;
  wire wr_blocked = prot_active && wr_flash;
  wire wr_ok = do_wr && wr_full16 && wr_mapped && !wr_blocked;
  wire [1:0] bresp_nxt = !wr_mapped ? `FWS_RESP_DECERR :
    (!wr_full16 || wr_blocked) ? `FWS_RESP_SLVERR : `FWS_RESP_OKAY;
  wire [2:0] pl_widx = 3'(wa[5:2] - `FWS_PL_FIRST_WIDX);

  // ==========================================
  // Operation control word
  wire [15:0] ctrl_hi_val = {start_r, suspend_req_r, sel_r[3], sel_r[2], sel_r[1], 2'b00, sel_r[0],
    8'h00};
  wire wr_start = wd_r[`FWS_START_BIT];
  // A start write keeps the prepared selection; other writes replace it
  wire [15:0] merged = wr_start ? (ctrl_hi_val | wd_r) : wd_r;
  wire [3:0] sel_new = {merged[`FWS_WPG_BIT], merged[`FWS_DWORD_PROG_SEL_BIT], merged[`FWS_SER_BIT],
    merged[`FWS_SPR_BIT]};
  wire ctrl_wr = wr_ok && wr_ctrl_hi;
  // Exactly one select bit names an operation
  wire fws_pkg::fws_op_t new_op = (sel_new == 4'h8) ? fws_pkg::FWS_OP_WORD :
    (sel_new == 4'h4) ? fws_pkg::FWS_OP_DWORD :
    (sel_new == 4'h2) ? fws_pkg::FWS_OP_ERASE :
    (sel_new == 4'h1) ? fws_pkg::FWS_OP_PROT : fws_pkg::FWS_OP_NONE;
  wire [31:0] addr_w = {pl_r[`FWS_PL_ADDR_HI], pl_r[`FWS_PL_ADDR_LO]};
  wire pair_hit = ({addr_w[31:2], 1'b0, addr_w[0]} == `FWS_PROT_PAIR_ADDR);
  wire limit_hit = (new_op == fws_pkg::FWS_OP_PROT) && pair_hit &&
    (nv_prot_enable_reg == `FWS_PEN_ALL_USED);
  wire start_req = ctrl_wr && wr_start;
  wire start_go = start_req && !merged[`FWS_SUSPEND_REQ_BIT] &&
    (new_op != fws_pkg::FWS_OP_NONE) && !limit_hit && !op_if.busy;
  wire limit_err = start_req && limit_hit;
  wire is_dword = (new_op == fws_pkg::FWS_OP_DWORD);

  assign op_if.start = start_go;
  assign op_if.op = new_op;
  assign op_if.suspend_req_req = ctrl_wr && wd_r[`FWS_SUSPEND_REQ_BIT];
  assign op_if.fl_done = fl_done;

  // ==========================================
  // Bus channels
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wd_r <= 16'h0000;
      wstrb_r <= 2'h0;
      bresp_r <= `FWS_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wd_r <= wdata[15:0];
        wstrb_r <= wstrb[1:0];
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= bresp_nxt;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // ==========================================
  // Control and status registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sel_r <= 4'h0;
      suspend_req_r <= 1'b0;
      start_r <= 1'b0;
    end else if (ctrl_wr) begin
      sel_r <= sel_new;
      suspend_req_r <= merged[`FWS_SUSPEND_REQ_BIT];
      start_r <= start_go || (start_r && op_if.busy &&
        !(merged[`FWS_SUSPEND_REQ_BIT] && !op_if.suspended));
    end else if (op_if.done || op_if.abort) begin
      sel_r <= 4'h0;
      start_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      temp_r <= 1'b0;
    end else if (wr_ok && wr_temp) begin
      temp_r <= wd_r[0] && (temp_r || fetch_from_flash);
    end
  end

  // Hardware set wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      err_r <= 2'h0;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      err_r[`FWS_RESUME_ERR_BIT] <= op_if.abort ||
        (err_r[`FWS_RESUME_ERR_BIT] && !(wr_ok && wr_err && wd_r[`FWS_RESUME_ERR_BIT]));
      err_r[`FWS_PROT_LIMIT_BIT] <= limit_err ||
        (err_r[`FWS_PROT_LIMIT_BIT] && !(wr_ok && wr_err && wd_r[`FWS_PROT_LIMIT_BIT]));
      irq_stat_r[`FWS_IRQ_DONE_BIT] <= op_if.done ||
        (irq_stat_r[`FWS_IRQ_DONE_BIT] && !(wr_ok && wr_istat && wd_r[`FWS_IRQ_DONE_BIT]));
      irq_stat_r[`FWS_IRQ_ERR_BIT] <= op_if.abort || limit_err ||
        (irq_stat_r[`FWS_IRQ_ERR_BIT] && !(wr_ok && wr_istat && wd_r[`FWS_IRQ_ERR_BIT]));
      if (wr_ok && wr_imask) begin
        irq_mask_r <= wd_r[1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================
  // Sector, address and data registers
  for (genvar i = 0; i < 8; i++) begin : g_plain
    wire clr_w = (i < 2) && op_if.erase_done;
    wire wen_w = wr_ok && wr_plain && (pl_widx == 3'(i));
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        pl_r[i] <= `FWS_REG_RST;
      end else if (clr_w) begin
        pl_r[i] <= `FWS_REG_RST;
      end else if (wen_w) begin
        pl_r[i] <= wd_r;
      end
    end
  end

  // ==========================================
  // Operation setup held toward the array
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fl_addr_r <= 32'h00000000;
      fl_wdata_r <= 64'h0000000000000000;
      fl_sectors_r <= 32'h00000000;
    end else if (start_go && new_op == fws_pkg::FWS_OP_ERASE) begin
      fl_sectors_r <= {pl_r[`FWS_PL_SECT_HI], pl_r[`FWS_PL_SECT_LO]};
    end else if (start_go) begin
      fl_addr_r <= {addr_w[31:3], addr_w[`FWS_PAIR_WORD_BIT] && !is_dword, addr_w[1:0]};
      fl_wdata_r <= {pl_r[`FWS_PL_DATA1_HI], pl_r[`FWS_PL_DATA1_LO],
        pl_r[`FWS_PL_DATA0_HI], pl_r[`FWS_PL_DATA0_LO]};
    end
  end

  assign fl_go = op_if.fl_go;
  assign fl_cmd = op_if.fl_cmd;
  assign fl_addr = fl_addr_r;
  assign fl_wdata = fl_wdata_r;
  assign fl_sectors = fl_sectors_r;
  assign fl_suspend_req = op_if.fl_suspend_req;
  assign fl_resume = op_if.fl_resume;
  assign fl_abort = op_if.fl_abort;

  // ==========================================
  // Read channel
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire rd_plain = (ra >= `FWS_PLAIN_FIRST_OFS) && (ra <= `FWS_PLAIN_LAST_OFS);
  wire [2:0] pl_ridx = 3'(ra[5:2] - `FWS_PL_FIRST_WIDX);
  wire rd_mapped = rd_plain || (ra == `FWS_CTRL0_LOW_OFS) || (ra == `FWS_CTRL0_HIGH_OFS) ||
    (ra == `FWS_ERROR_OFS) || (ra == `FWS_TEMP_UNPROT_OFS) || (ra == `FWS_IRQ_STAT_OFS) ||
    (ra == `FWS_IRQ_MASK_OFS) || (ra == `FWS_PROT_STAT_OFS);

  always_comb begin
    rd_val = 16'h0000;
    case (ra)
      `FWS_CTRL0_LOW_OFS: rd_val = {14'h0000, op_if.suspended, op_if.busy};
      `FWS_CTRL0_HIGH_OFS: rd_val = ctrl_hi_val;
      `FWS_ERROR_OFS: rd_val = {14'h0000, err_r};
      `FWS_TEMP_UNPROT_OFS: rd_val = {15'h0000, temp_r};
      `FWS_IRQ_STAT_OFS: rd_val = {14'h0000, irq_stat_r};
      `FWS_IRQ_MASK_OFS: rd_val = {14'h0000, irq_mask_r};
      `FWS_PROT_STAT_OFS: rd_val = {15'h0000, prot_active};
      default: rd_val = rd_plain ? pl_r[pl_ridx] : 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 16'h0000;
      rresp_r <= `FWS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_mapped ? `FWS_RESP_OKAY : `FWS_RESP_DECERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = {16'h0000, rdata_r};
  assign rresp = rresp_r;

  // ==========================================
  // Checks
  AST_BYTE_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
    do_wr && wr_mapped && !wr_full16 |=> bvalid && bresp == `FWS_RESP_SLVERR)
    else $error("partial write not refused");

  AST_WORD_GO: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_go && new_op == fws_pkg::FWS_OP_WORD && !op_if.suspended
    |=> fl_go && fl_cmd == fws_pkg::FWS_OP_WORD && fl_wdata[31:0] == $past(
    {pl_r[`FWS_PL_DATA0_HI], pl_r[`FWS_PL_DATA0_LO]}))
    else $error("word program not launched with its data");

  AST_DWORD_ALIGN: assert property (@(posedge ref_clk) disable iff (!resetn)
    fl_go && fl_cmd == fws_pkg::FWS_OP_DWORD |-> !fl_addr[`FWS_PAIR_WORD_BIT])
    else $error("double word program on odd word");

  AST_SECTOR_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_if.erase_done |=> pl_r[`FWS_PL_SECT_LO] == 16'h0000 && pl_r[`FWS_PL_SECT_HI] == 16'h0000)
    else $error("sector mask not cleared after erase");

  AST_RESUME_ERR: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_if.abort |=> err_r[`FWS_RESUME_ERR_BIT] && !start_r)
    else $error("abort did not flag resume error");

  AST_CANCEL: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_req && new_op == fws_pkg::FWS_OP_NONE |=> !fl_go)
    else $error("operation launched without a selection");

  AST_PROT_BLOCK: assert property (@(posedge ref_clk) disable iff (!resetn)
    do_wr && wr_flash && prot_active |=> bvalid && bresp == `FWS_RESP_SLVERR && !fl_go)
    else $error("control write accepted under access protection");

  AST_TEMP_UNPROT: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(temp_r) |-> $past(fetch_from_flash))
    else $error("temporary unprotect set outside flash code");

  AST_START_HELD: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_if.busy |-> start_r)
    else $error("start bit low while operation runs");

endmodule : fws_top

/* testbench/fws_flash_model.sv */
`timescale 1ns/10ps
// ==========================================
// Array stand-in: answers a launch or resume lat+1 cycles after taking it unless a suspend or abort comes first
module fws_flash_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fl_go,
  input wire logic fl_suspend_req,
  input wire logic fl_resume,
  input wire logic fl_abort,
  input wire logic [7:0] lat,
  output logic fl_done
);
  logic run_r;
  logic [7:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    fl_done <= 1'b0;
    if (!resetn) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (fl_go || fl_resume) begin
      run_r <= 1'b1;
      cnt_r <= lat;
    end else if (fl_suspend_req || fl_abort) begin
      run_r <= 1'b0;
    end else if (run_r && cnt_r == 8'h00) begin
      run_r <= 1'b0;
      fl_done <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : fws_flash_model

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`include "fws_defines.svh"
module tb_top;
  localparam logic [7:0] C0L = `FWS_CTRL0_LOW_OFS, C0H = `FWS_CTRL0_HIGH_OFS, ERR = `FWS_ERROR_OFS;
  localparam logic [7:0] TMP = `FWS_TEMP_UNPROT_OFS, IST = `FWS_IRQ_STAT_OFS, PST = `FWS_PROT_STAT_OFS;
  logic ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready, fetch_from_flash;
  logic access_prot_bit, fl_done, awready, wready, bvalid, arready, rvalid, irq;
  logic fl_go, fl_suspend_req, fl_resume, fl_abort;
  logic [7:0] awaddr, araddr, lat;
  logic [31:0] wdata, rdata, fl_addr, fl_sectors, rv;
  logic [3:0] wstrb;
  logic [15:0] nv_prot_enable_reg;
  logic [1:0] bresp, rresp, rr;
  logic [63:0] fl_wdata;
  fws_pkg::fws_op_t fl_cmd;
  int miscompares = 0, check_count = 0, go_n = 0, sus_n = 0, res_n = 0, abt_n = 0, g, h;

  fws_top uut (.ref_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
    .fetch_from_flash, .access_prot_bit, .nv_prot_enable_reg, .fl_go, .fl_cmd, .fl_addr,
    .fl_wdata, .fl_sectors, .fl_suspend_req, .fl_resume, .fl_abort, .fl_done);
  fws_flash_model u_fl (.ref_clk, .resetn, .fl_go, .fl_suspend_req, .fl_resume, .fl_abort, .lat,
    .fl_done);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Launch, suspend, resume and abort pulse counters
  always @(posedge ref_clk) begin
    go_n <= go_n + int'(fl_go === 1'b1);
    sus_n <= sus_n + int'(fl_suspend_req === 1'b1);
    res_n <= res_n + int'(fl_resume === 1'b1);
    abt_n <= abt_n + int'(fl_abort === 1'b1);
  end

  // ==========================================
  // Bus tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0,
      input logic [3:0] s = 4'hf);
    logic ah;
    logic wh;
    ah = 1'b0;
    wh = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge ref_clk);
      ah = ah | awready;
      wh = wh | wready;
      awvalid <= !ah;
      wvalid <= !wh;
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
  endtask : rdr

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
    rdr(a);
    chk($sformatf("reg %h", a), {16'h0000, e}, rv);
    chk("rresp", 32'(er), 32'(rr));
  endtask : rd

  task automatic ld(input logic [15:0] al, ah, d0l, d0h);
    wr(8'h10, al);
    wr(8'h14, ah);
    wr(8'h18, d0l);
    wr(8'h1c, d0h);
  endtask : ld

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rdr(C0L);
      n++;
    end while (rv[0] !== 1'b0 && n < 200);
    chk("idle", 32'h0, 32'(rv[0]));
  endtask : wait_idle

  // ==========================================
  // Scenarios
  task automatic t_prot();
    rd(PST, 16'h0001);
    wr(C0H, 16'h2000, 2'h2);
    wr(8'h10, 16'h1234, 2'h2);
    wr(TMP, 16'h0001);
    rd(TMP, 16'h0000);
    fetch_from_flash <= 1'b1;
    wr(TMP, 16'h0001);
    fetch_from_flash <= 1'b0;
    rd(PST, 16'h0000);
    wr(TMP, 16'h0000);
    rd(PST, 16'h0001);
    fetch_from_flash <= 1'b1;
    wr(TMP, 16'h0001);
    fetch_from_flash <= 1'b0;
    $display("protection test done");
  endtask : t_prot

  task automatic t_word();
    wr(8'h34, 16'h0003);
    wr(C0H, 16'h2000);
    ld(16'h5554, 16'h0002, 16'haaaa, 16'h5555);
    wr(8'h18, 16'h1234, 2'h2, 4'h1);
    rd(8'h18, 16'haaaa);
    g = go_n;
    wr(C0H, 16'h8000);
    chk("fl_cmd", 32'(fws_pkg::FWS_OP_WORD), 32'(fl_cmd));
    chk("fl_addr", 32'h00025554, fl_addr);
    chk("fl_wdata", 32'h5555aaaa, fl_wdata[31:0]);
    rd(C0H, 16'ha000);
    chk("go count", 32'(g + 1), 32'(go_n));
    wait_idle();
    rd(C0H, 16'h0000);
    rd(IST, 16'h0001);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IST, 16'h0003);
    chk("irq", 32'h0, {31'h0, irq});
    wr(C0H, 16'h1000);
    ld(16'h555c, 16'h0003, 16'h1111, 16'h2222);
    wr(8'h20, 16'h3333);
    wr(8'h24, 16'h4444);
    wr(C0H, 16'h8000);
    chk("fl_cmd", 32'(fws_pkg::FWS_OP_DWORD), 32'(fl_cmd));
    chk("fl_addr", 32'h00035558, fl_addr);
    chk("fl_wdata lo", 32'h22221111, fl_wdata[31:0]);
    chk("fl_wdata hi", 32'h44443333, fl_wdata[63:32]);
    wait_idle();
    $display("program test done");
  endtask : t_word

  task automatic t_erase();
    wr(C0H, 16'h0800);
    wr(8'h08, 16'h0003);
    wr(C0H, 16'h8000);
    chk("fl_cmd", 32'(fws_pkg::FWS_OP_ERASE), 32'(fl_cmd));
    chk("fl_sectors", 32'h00000003, fl_sectors);
    g = sus_n;
    wr(C0H, 16'h4000);
    rd(C0L, 16'h0002);
    chk("suspend_req count", 32'(g + 1), 32'(sus_n));
    wr(C0H, 16'h0000);
    wr(C0H, 16'h2000);
    ld(16'h5554, 16'h0004, 16'haaaa, 16'h5555);
    g = go_n;
    wr(C0H, 16'h8000);
    chk("fl_cmd", 32'(fws_pkg::FWS_OP_WORD), 32'(fl_cmd));
    h = sus_n;
    wr(C0H, 16'h4000);
    rd(C0L, 16'h0003);
    chk("go count", 32'(g + 1), 32'(go_n));
    chk("suspend_req count", 32'(h), 32'(sus_n));
    wait_idle();
    rd(C0L, 16'h0002);
    rd(8'h08, 16'h0003);
    wr(C0H, 16'h0800);
    g = res_n;
    wr(C0H, 16'h8000);
    rd(C0L, 16'h0001);
    chk("resume count", 32'(g + 1), 32'(res_n));
    wait_idle();
    rd(8'h08, 16'h0000);
    rd(8'h0c, 16'h0000);
    $display("erase suspend test done");
  endtask : t_erase

  task automatic t_abort();
    wr(IST, 16'h0003);
    wr(C0H, 16'h2000);
    wr(C0H, 16'h8000);
    wr(C0H, 16'h4000);
    wr(C0H, 16'h1000);
    g = abt_n;
    wr(C0H, 16'h8000);
    rd(C0H, 16'h0000);
    chk("abort count", 32'(g + 1), 32'(abt_n));
    rd(ERR, 16'h0001);
    chk("irq", 32'h1, {31'h0, irq});
    rd(IST, 16'h0002);
    wr(ERR, 16'h0001);
    wr(IST, 16'h0003);
    rd(ERR, 16'h0000);
    g = go_n;
    wr(C0H, 16'h2000);
    wr(C0H, 16'h0000);
    wr(C0H, 16'h8000);
    wr(C0H, 16'h6000);
    wr(C0H, 16'h8000);
    wr(C0H, 16'h0000);
    rd(C0L, 16'h0000);
    chk("go count", 32'(g), 32'(go_n));
    $display("abort test done");
  endtask : t_abort

  task automatic t_setprot();
    wr(C0H, 16'h0100);
    ld(16'hdfbc, 16'h0008, 16'hfffe, 16'hffff);
    wr(C0H, 16'h8000);
    chk("fl_cmd", 32'(fws_pkg::FWS_OP_PROT), 32'(fl_cmd));
    chk("fl_addr", 32'h0008dfbc, fl_addr);
    chk("fl_wdata", 32'h0000fffe, {16'h0000, fl_wdata[15:0]});
    wait_idle();
    nv_prot_enable_reg <= 16'h0000;
    g = go_n;
    wr(C0H, 16'h0100);
    wr(C0H, 16'h8000);
    rd(ERR, 16'h0002);
    chk("go count", 32'(g), 32'(go_n));
    rd(8'h3c, 16'h0000, 2'h3);
    wr(8'h3c, 16'h0000, 2'h3);
    $display("set protection test done");
  endtask : t_setprot

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    results();
  end

  initial begin
    {awvalid, wvalid, arvalid, fetch_from_flash, access_prot_bit, resetn} = 6'h00;
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    lat = 8'h28;
    nv_prot_enable_reg = 16'hffff;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_prot();
    t_word();
    lat <= 8'h1e;
    t_erase();
    lat <= 8'h3c;
    t_abort();
    lat <= 8'h02;
    t_setprot();
    results();
  end
endmodule : tb_top
